/* rtl/htv_ctrl.sv */
`timescale 1ns/1ps
// Function
// RULE_01 - impdef trap routes impdef encodings to hyp
// RULE_02 - group3 trap catches listed feature ID reads
// RULE_03 - optional reserved ID encodings also trapped
// RULE_04 - group2 traps cache ID reads, selector writes
// RULE_05 - group1 traps memory/revision/aux/MPU ID reads
// RULE_06 - group0 traps alt-ISA and FP ID reads
// RULE_07 - FP ID writes ignored; undef beats trap
// RULE_08 - event-wait trap, EL0 undef takes priority
// RULE_09 - irq-wait trap, EL0 undef takes priority
// RULE_10 - failed-condition waits never trap
// RULE_11 - wait trap only when wait would block
// RULE_12 - default cacheable forces stage2 enable on
// RULE_13 - default map gives normal WB executable attrs
// RULE_14 - barrier upgrade field sets minimum domain
// RULE_15 - barrier domain merged as stage combine
// RULE_16 - force broadcast of EL1 invalidate-all ops
// RULE_17 - guest serror pending gated by route/override
// RULE_18 - guest irq pending gated by route/override
// RULE_19 - guest fiq pending gated by route/override
// RULE_20 - serror override forced on under route-all
// RULE_21 - irq override forced on under route-all
// RULE_22 - fiq override enables guest fiq signalling
// RULE_23 - fiq override forced on under route-all
// RULE_24 - register reached by coprocessor move encoding
// RULE_25 - fields reset zero, bit 19 reads zero
// RULE_26 - trapped op suppressed, hyp exception raised
module htv_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,

  // coprocessor move request
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [1:0] cp_el,
  input wire logic cp_cond_pass,
  input wire logic [3:0] cp_coproc,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,

  // wait instruction request
  input wire logic wt_valid,
  input wire logic wt_is_irq,
  input wire logic [1:0] wt_el,
  input wire logic wt_cond_pass,
  input wire logic wt_would_block,

  // processor state context
  input wire logic el0_wfe_allow,
  input wire logic el0_wfi_allow,
  input wire logic alt_isa_undef_el0,
  input wire logic state_serror_mask,
  input wire logic state_irq_mask,
  input wire logic state_fiq_mask,
  input wire logic mmu_default_map,

  // barrier and invalidate request
  input wire logic br_valid,
  input wire logic [1:0] br_el,
  input wire logic [1:0] br_domain,
  input wire logic inv_valid,
  input wire logic [1:0] inv_el,

  // coprocessor answer
  output logic cp_done,
  output logic [31:0] cp_rdata,
  output htv_pkg::htv_exc_t cp_exc,

  // wait answer
  output logic wt_done,
  output htv_pkg::htv_exc_t wt_exc,
  output logic wt_sleep,

  // barrier and invalidate answer
  output logic br_done,
  output logic [1:0] br_eff_domain,
  output logic inv_done,
  output logic inv_broadcast,

  // memory regime controls
  output logic stage2_eff,
  output logic [7:0] def_map_attr,
  output logic def_map_shared,
  output logic def_map_exec,

  // guest interrupt lines
  output logic guest_serror,
  output logic guest_irq,
  output logic guest_fiq
);
  import htv_pkg::*;

  // ==========================================================
  // merge of two shareability domains, widest wins
  // order: none, inner, outer, full system
  // same merge as for two translation stages
  // used by the barrier path only
  function automatic logic [1:0] htv_merge(input logic [1:0] a, input logic [1:0] b);
    logic [1:0] r;
    r = HTV_SH_NONE;
    if (a == HTV_SH_SYS || b == HTV_SH_SYS) begin
      r = HTV_SH_SYS;
    end else if (a == HTV_SH_OUTER || b == HTV_SH_OUTER) begin
      r = HTV_SH_OUTER;
    end else if (a == HTV_SH_INNER || b == HTV_SH_INNER) begin
      r = HTV_SH_INNER;
    end
    return r;
  endfunction

  // true for EL0 or EL1 origin
  // hyp level and above never see guest traps
  function automatic logic htv_guest(input logic [1:0] el);
    return (el == HTV_EL0) || (el == HTV_EL1);
  endfunction

  // ==========================================================
  // configuration register
  logic [31:0] hyp_config_reg;
  logic [31:0] hyp_config_next;

  // overrides as the guest logic sees them
  // forcing lives only here: a direct read
  // still returns the stored override bits
  // route-all forces all three overrides on
  wire logic route_all = hyp_config_reg[HTV_B_ROUTE_ALL];
  wire logic serr_ovr_eff = hyp_config_reg[HTV_B_SERR_OVR] | route_all; // [RULE_20]
  wire logic irq_ovr_eff = hyp_config_reg[HTV_B_IRQ_OVR] | route_all; // [RULE_21]
  wire logic fiq_ovr_eff = hyp_config_reg[HTV_B_FIQ_OVR] | route_all; // [RULE_23]

  // ==========================================================
  // coprocessor decode
  // fields are decoded in the request cycle only
  // nothing here looks at the condition input
  wire logic is_p15 = (cp_coproc == HTV_COPROC);
  wire logic hit_cfg = is_p15 && cp_opc1 == HTV_OPC1 && cp_crn == HTV_CRN &&
                       cp_crm == HTV_CRM && cp_opc2 == HTV_OPC2; // [RULE_24]
  wire logic id_space = is_p15 && cp_opc1 == 3'h0 && cp_crn == 4'h0;
  wire logic el1 = (cp_el == HTV_EL1);
  wire logic el0 = (cp_el == HTV_EL0);
  wire logic rd = ~cp_write;

  // impdef encoding space in CRn 9, 10, 11
  // EL0 access here is left to the core's undef path
  wire logic imp9 = cp_crn == 4'h9 && (cp_crm <= 4'h2 || (cp_crm >= 4'h5 && cp_crm <= 4'h8));
  wire logic imp10 = cp_crn == 4'hA && (cp_crm == 4'h0 || cp_crm == 4'h1 || cp_crm == 4'h4 || cp_crm == 4'h8);
  wire logic imp11 = cp_crn == 4'hB && (cp_crm <= 4'h8 || cp_crm == 4'hF);
  wire logic imp_hit = is_p15 && (imp9 || imp10 || imp11);
  wire logic tr_imp = hyp_config_reg[HTV_B_IMPDEF] && el1 && imp_hit; // [RULE_01]

  // group 3 feature ID reads
  // reads only; writes to these encodings pass
  // EL1 origin only
  wire logic g3_req = id_space && ((cp_crm >= 4'h3 && cp_crm <= 4'h7 && cp_opc2 <= 3'h1) ||
                      (cp_crm == 4'h3 && cp_opc2 == 3'h2) ||
                      (cp_crm == 4'h5 && (cp_opc2 == 3'h4 || cp_opc2 == 3'h5))); // [RULE_02]
  // reserved encodings: this build traps them all
  wire logic g3_opt = id_space && ((cp_crm == 4'h2 && cp_opc2 == 3'h7) ||
                      (cp_crm >= 4'h3 && cp_crm <= 4'h7)); // [RULE_03]
  wire logic tr_g3 = hyp_config_reg[HTV_B_ID3] && el1 && rd && (g3_req || g3_opt);

  // group 2: cache type/size/level (opc1 0/1) and size select (opc1 2)
  // besides the impdef trap, the only group that also traps a write; EL0 traps here and in group 0
  // selector write trapped so guest cannot steer it
  wire logic ctype_hit = id_space && cp_crm == 4'h0 && cp_opc2 == 3'h1;
  wire logic ccs_hit = is_p15 && cp_opc1 == 3'h1 && cp_crn == 4'h0 && cp_crm == 4'h0 &&
                       (cp_opc2 == 3'h0 || cp_opc2 == 3'h1);
  wire logic csel_hit = is_p15 && cp_opc1 == 3'h2 && cp_crn == 4'h0 && cp_crm == 4'h0 && cp_opc2 == 3'h0;
  wire logic tr_g2 = hyp_config_reg[HTV_B_ID2] && htv_guest(cp_el) &&
                     ((rd && (ctype_hit || ccs_hit || csel_hit)) || (cp_write && csel_hit)); // [RULE_04]

  // group 1: tcm, tlb, revision, mpu type, aux ID
  // EL1 reads only
  // aux ID sits at opc1 1, the rest at opc1 0
  wire logic g1_hit = (id_space && cp_crm == 4'h0 && (cp_opc2 == 3'h2 || cp_opc2 == 3'h3 ||
                      cp_opc2 == 3'h4 || cp_opc2 == 3'h6)) ||
                      (ccs_hit && cp_opc2 == 3'h7);
  wire logic aidr_hit = is_p15 && cp_opc1 == 3'h1 && cp_crn == 4'h0 && cp_crm == 4'h0 && cp_opc2 == 3'h7;
  wire logic tr_g1 = hyp_config_reg[HTV_B_ID1] && el1 && rd && (g1_hit || aidr_hit); // [RULE_05]

  // group 0: alt-ISA ID (cp14) and FP system ID (cp10)
  // FP ID writes never trap, they are dropped
  // undef at EL0 outranks the hyp trap
  wire logic alt_hit = cp_coproc == 4'hE && cp_opc1 == 3'h7 && cp_crn == 4'h0;
  wire logic fpid_hit = cp_coproc == 4'hA && cp_opc1 == 3'h7 && cp_crn == 4'h0;
  wire logic undef_alt = el0 && alt_hit && alt_isa_undef_el0; // [RULE_07]
  wire logic tr_g0 = hyp_config_reg[HTV_B_ID0] && rd &&
                     ((el1 && (alt_hit || fpid_hit)) || (el0 && alt_hit && !alt_isa_undef_el0)); // [RULE_06]

  // any trap suppresses the move: no write lands
  // config encoding answers only the hyp level
  // guest access to it answers quietly with zero data
  // undef wins over a hyp trap in the answer code
  wire logic cp_trap = tr_imp || tr_g3 || tr_g2 || tr_g1 || tr_g0;
  wire logic cfg_acc = hit_cfg && !htv_guest(cp_el);
  wire logic cfg_wr = cp_valid && cfg_acc && cp_write && !cp_trap; // [RULE_26]
  wire htv_exc_t cp_exc_next = undef_alt ? HTV_EXC_UNDEF : (cp_trap ? HTV_EXC_HYP : HTV_EXC_NONE);
  // direct read returns stored bits only
  // forced overrides never show up here
  wire logic [31:0] cp_rdata_next = (cp_valid && cfg_acc && rd) ? hyp_config_reg : 32'h0000_0000;

  // write path: masked, reserved bits held at zero
  // bit 19 and uncovered bits read as zero
  assign hyp_config_next = cfg_wr ? (cp_wdata & HTV_WMASK) : hyp_config_reg; // [RULE_25]

  // ==========================================================
  // wait instruction decision
  // undef at EL0 outranks the hyp trap
  // failed condition: no trap, no sleep
  // a wait that may wake early is let through
  // sleep only when nothing else claims the wait
  wire logic wt_en = wt_is_irq ? hyp_config_reg[HTV_B_WAIT_IRQ] : hyp_config_reg[HTV_B_WAIT_EV];
  wire logic wt_allow0 = wt_is_irq ? el0_wfi_allow : el0_wfe_allow;
  wire logic wt_und = wt_el == HTV_EL0 && !wt_allow0 && wt_cond_pass; // [RULE_08] [RULE_09]
  wire logic wt_trap = wt_en && htv_guest(wt_el) && wt_cond_pass && wt_would_block && !wt_und; // [RULE_10] [RULE_11]
  wire htv_exc_t wt_exc_next = wt_und ? HTV_EXC_UNDEF : (wt_trap ? HTV_EXC_HYP : HTV_EXC_NONE);
  wire logic wt_sleep_next = wt_valid && wt_cond_pass && wt_would_block && !wt_und && !wt_trap;

  // ==========================================================
  // barrier upgrade and broadcast
  // upgrade only widens, never narrows a barrier
  // hyp-level barriers keep their own domain
  // broadcast applies to EL1 invalidate-all only
  wire logic [1:0] bar_up = hyp_config_reg[HTV_B_BAR_UP_HI:HTV_B_BAR_UP_LO];
  wire logic [1:0] br_dom_next = htv_guest(br_el) ? htv_merge(bar_up, br_domain) : br_domain; // [RULE_14] [RULE_15]
  wire logic inv_bc_next = inv_valid && inv_el == HTV_EL1 && hyp_config_reg[HTV_B_FORCE_BC]; // [RULE_16]

  // ==========================================================
  // regime controls
  // default cacheable forces stage 2 on for the guest
  // the stored stage 2 bit still reads back as written
  // hyp regime untouched: attrs only for the guest map
  wire logic def_cache = hyp_config_reg[HTV_B_DEF_CACHE];
  wire logic stage2_next = hyp_config_reg[HTV_B_STAGE2] | def_cache; // [RULE_12]
  wire logic dm_on = def_cache && mmu_default_map;
  wire logic [7:0] attr_next = dm_on ? HTV_DEF_ATTR : 8'h00; // [RULE_13]

  // ==========================================================
  // guest interrupt gating
  // route-all kills every guest line even though it
  // forces the overrides on: both terms are needed
  // pending bit alone never raises a line
  wire logic vse_next = hyp_config_reg[HTV_B_SERR_PEND] && !route_all && serr_ovr_eff; // [RULE_17] [RULE_20]
  wire logic vir_next = hyp_config_reg[HTV_B_IRQ_PEND] && !route_all && irq_ovr_eff; // [RULE_18] [RULE_21]
  wire logic vfq_next = hyp_config_reg[HTV_B_FIQ_PEND] && !route_all && fiq_ovr_eff; // [RULE_19] [RULE_22]
  // physical masks do not gate the guest lines once overridden
  wire logic unused_masks = state_serror_mask ^ state_irq_mask ^ state_fiq_mask;

  // ==========================================================
  // config register storage
  // changes reach the level outputs one cycle later
  // sync reset clears every covered control bit
  always_ff @(posedge clk) begin
    if (rst) begin
      hyp_config_reg <= HTV_RESET; // [RULE_25]
    end else begin
      hyp_config_reg <= hyp_config_next;
    end
  end

  // ==========================================================
  // answer pipeline: each answer stands one cycle after its request
  // one block per interface, all answers quiet when idle

  // move answer
  always_ff @(posedge clk) begin
    if (rst) begin
      cp_done <= 1'b0;
      cp_rdata <= 32'h0000_0000;
      cp_exc <= HTV_EXC_NONE;
    end else begin
      cp_done <= cp_valid;
      cp_rdata <= cp_rdata_next;
      cp_exc <= cp_valid ? cp_exc_next : HTV_EXC_NONE; // [RULE_26]
    end
  end

  // wait answer
  always_ff @(posedge clk) begin
    if (rst) begin
      wt_done <= 1'b0;
      wt_exc <= HTV_EXC_NONE;
      wt_sleep <= 1'b0;
    end else begin
      wt_done <= wt_valid;
      wt_exc <= wt_valid ? wt_exc_next : HTV_EXC_NONE;
      wt_sleep <= wt_sleep_next;
    end
  end

  // barrier answer
  always_ff @(posedge clk) begin
    if (rst) begin
      br_done <= 1'b0;
      br_eff_domain <= HTV_SH_NONE;
    end else begin
      br_done <= br_valid;
      br_eff_domain <= br_valid ? br_dom_next : HTV_SH_NONE;
    end
  end

  // invalidate answer
  always_ff @(posedge clk) begin
    if (rst) begin
      inv_done <= 1'b0;
      inv_broadcast <= 1'b0;
    end else begin
      inv_done <= inv_valid;
      inv_broadcast <= inv_bc_next;
    end
  end

  // ==========================================================
  // level outputs, one cycle behind the register
  // regime controls
  always_ff @(posedge clk) begin
    if (rst) begin
      stage2_eff <= 1'b0;
      def_map_attr <= 8'h00;
      def_map_shared <= 1'b0;
      def_map_exec <= 1'b0;
    end else begin
      stage2_eff <= stage2_next;
      def_map_attr <= attr_next;
      def_map_shared <= 1'b0; // non-shareable
      def_map_exec <= dm_on;
    end
  end

  // guest interrupt lines
  always_ff @(posedge clk) begin
    if (rst) begin
      guest_serror <= 1'b0;
      guest_irq <= 1'b0;
      guest_fiq <= 1'b0;
    end else begin
      guest_serror <= vse_next;
      guest_irq <= vir_next;
      guest_fiq <= vfq_next;
    end
  end
endmodule

/* rtl/htv_pkg.sv */
package htv_pkg;
  // ==========================================================
  // register access encoding (system coprocessor move)
  localparam logic [3:0] HTV_COPROC = 4'hF;
  localparam logic [2:0] HTV_OPC1 = 3'h4;
  localparam logic [3:0] HTV_CRN = 4'h1;
  localparam logic [3:0] HTV_CRM = 4'h1;
  localparam logic [2:0] HTV_OPC2 = 3'h0;
  // ==========================================================
  // field positions in hyp_config
  localparam int HTV_B_ROUTE_ALL = 27;
  localparam int HTV_B_IMPDEF = 20;
  localparam int HTV_B_RSVD19 = 19;
  localparam int HTV_B_ID3 = 18;
  localparam int HTV_B_ID2 = 17;
  localparam int HTV_B_ID1 = 16;
  localparam int HTV_B_ID0 = 15;
  localparam int HTV_B_WAIT_EV = 14;
  localparam int HTV_B_WAIT_IRQ = 13;
  localparam int HTV_B_DEF_CACHE = 12;
  localparam int HTV_B_BAR_UP_HI = 11;
  localparam int HTV_B_BAR_UP_LO = 10;
  localparam int HTV_B_FORCE_BC = 9;
  localparam int HTV_B_SERR_PEND = 8;
  localparam int HTV_B_IRQ_PEND = 7;
  localparam int HTV_B_FIQ_PEND = 6;
  localparam int HTV_B_SERR_OVR = 5;
  localparam int HTV_B_IRQ_OVR = 4;
  localparam int HTV_B_FIQ_OVR = 3;
  localparam int HTV_B_STAGE2 = 0;
  // writable bits: 27, 20, 18..3, 0 (bit 19 reserved)
  localparam logic [31:0] HTV_WMASK = 32'h0817_FFF9;
  localparam logic [31:0] HTV_RESET = 32'h0000_0000;
  // ==========================================================
  // shareability domain codes
  localparam logic [1:0] HTV_SH_NONE = 2'h0;
  localparam logic [1:0] HTV_SH_INNER = 2'h1;
  localparam logic [1:0] HTV_SH_OUTER = 2'h2;
  localparam logic [1:0] HTV_SH_SYS = 2'h3;
  // default-map attribute byte: normal, inner/outer WB RA/WA
  localparam logic [7:0] HTV_DEF_ATTR = 8'hFF;
  // exception level codes
  localparam logic [1:0] HTV_EL0 = 2'h0;
  localparam logic [1:0] HTV_EL1 = 2'h1;
  typedef enum logic [1:0] {
    HTV_EXC_NONE = 2'b00,
    HTV_EXC_HYP = 2'b01,
    HTV_EXC_UNDEF = 2'b10
  } htv_exc_t;
endpackage

/* tb/htv_ctrl_sva.sv */
`timescale 1ns/1ps
module htv_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // coprocessor move
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic [1:0] cp_el,
  input wire logic [3:0] cp_coproc,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  input wire logic cp_done,
  input wire logic [31:0] cp_rdata,
  input wire htv_pkg::htv_exc_t cp_exc,
  // levels
  input wire logic stage2_eff,
  input wire logic guest_serror,
  input wire logic guest_irq,
  input wire logic guest_fiq
);
  import htv_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // shadow of the config register
  logic [31:0] cfg_reg;
  wire [17:0] enc = {cp_coproc, cp_opc1, cp_crn, cp_crm, cp_opc2};
  wire cfg_hit = enc == {HTV_COPROC, HTV_OPC1, HTV_CRN, HTV_CRM, HTV_OPC2};
  wire hyp_cfg = cp_valid && cfg_hit && cp_el[1];
  // only hyp-level writes land
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= HTV_RESET;
    end else if (hyp_cfg && cp_write) begin
      cfg_reg <= cp_wdata & HTV_WMASK;
    end
  end
  // ==========================================================
  // properties
  a_move_answer_time: assert property (cp_done == $past(cp_valid))
    else $error("move answer not one cycle after request");
  a_cfg_read_back: assert property (hyp_cfg && !cp_write |=> cp_rdata == $past(cfg_reg))
    else $error("config read data wrong");
  a_cfg_guest_refuse: assert property (
    cp_valid && cfg_hit && !cp_el[1] |=> cp_exc == HTV_EXC_NONE && cp_rdata == 32'h0)
    else $error("guest config access not refused quietly");
  a_cache_id_trap: assert property (
    cp_valid && !cp_write && !cp_el[1] && cfg_reg[17] && enc == {4'hF, 3'h0, 4'h0, 4'h0, 3'h1} |=> cp_exc == HTV_EXC_HYP)
    else $error("cache type read not trapped");
  a_serror_gate: assert property (guest_serror == $past(cfg_reg[8] && !cfg_reg[27] && cfg_reg[5]))
    else $error("guest serror gating wrong");
  a_irq_gate: assert property (guest_irq == $past(cfg_reg[7] && !cfg_reg[27] && cfg_reg[4]))
    else $error("guest irq gating wrong");
  a_fiq_gate: assert property (guest_fiq == $past(cfg_reg[6] && !cfg_reg[27] && cfg_reg[3]))
    else $error("guest fiq gating wrong");
  a_stage2_force: assert property (stage2_eff == $past(cfg_reg[0] || cfg_reg[12]))
    else $error("stage2 enable wrong");
endmodule
bind htv_ctrl htv_ctrl_sva u_sva (.*);

/* tb/htv_ctrl_tb.sv */
`timescale 1ns/1ps
module htv_ctrl_tb;
  import htv_pkg::*;
  localparam logic [17:0] CFG = {HTV_COPROC, HTV_OPC1, HTV_CRN, HTV_CRM, HTV_OPC2};
  localparam logic [17:0] ALT = {4'hE, 3'h7, 4'h0, 4'h0, 3'h0};
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cp_valid = '0, cp_write = '0, cp_cond_pass = '0, wt_valid = '0, wt_is_irq = '0, wt_cond_pass = '0;
  logic wt_would_block = '0, el0_wfe_allow = '0, el0_wfi_allow = '0, alt_isa_undef_el0 = '0;
  logic state_serror_mask = '0, state_irq_mask = '0, state_fiq_mask = '0;
  logic mmu_default_map = '1, br_valid = '0, inv_valid = '0;
  logic [1:0] cp_el = '0, wt_el = '0, br_el = '0, br_domain = '0, inv_el = '0;
  logic [2:0] cp_opc1 = '0, cp_opc2 = '0;
  logic [3:0] cp_coproc = '0, cp_crn = '0, cp_crm = '0;
  logic [31:0] cp_wdata = '0, cp_rdata;
  logic cp_done, wt_done, wt_sleep, br_done, inv_done, inv_broadcast, stage2_eff, def_map_shared;
  logic def_map_exec, guest_serror, guest_irq, guest_fiq;
  logic [7:0] def_map_attr;
  logic [1:0] br_eff_domain;
  htv_exc_t cp_exc, wt_exc;
  int n_errors = 0;
  int comparisons = 0;
  htv_ctrl u_dut (.*);
  // free-running clock
  initial forever #50 clk = ~clk;
  // ==========================================================
  // access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cp(input logic w, input logic [1:0] el, input logic [17:0] enc, input logic [31:0] wd,
                    input logic [1:0] ex, input logic [31:0] rd);
    @(posedge clk);
    #1;
    {cp_valid, cp_write, cp_el, cp_wdata} = {1'h1, w, el, wd};
    {cp_coproc, cp_opc1, cp_crn, cp_crm, cp_opc2} = enc;
    @(posedge clk);
    #1;
    cp_valid = 1'h0;
    chk({cp_done, cp_exc, cp_rdata}, {1'h1, ex, rd}, "move answer");
  endtask
  task automatic wt(input logic irq, input logic [1:0] el, input logic ok, input logic cnd, input logic blk,
                    input logic [1:0] ex, input logic slp);
    @(posedge clk);
    #1;
    {wt_valid, wt_is_irq, wt_el, el0_wfe_allow, el0_wfi_allow} = {1'h1, irq, el, ok, ok};
    {wt_cond_pass, wt_would_block} = {cnd, blk};
    @(posedge clk);
    #1;
    wt_valid = 1'h0;
    chk({wt_done, wt_exc, wt_sleep}, {1'h1, ex, slp}, "wait answer");
  endtask
  task automatic bi(input logic [1:0] el, input logic [1:0] dom, input logic [1:0] exd, input logic exb);
    @(posedge clk);
    #1;
    {br_valid, inv_valid, br_el, inv_el, br_domain} = {2'h3, el, el, dom};
    @(posedge clk);
    #1;
    {br_valid, inv_valid} = 2'h0;
    chk({br_done, br_eff_domain, inv_done, inv_broadcast}, {1'h1, exd, 1'h1, exb}, "barrier answer");
  endtask
  task automatic lv(input logic [31:0] v, input logic [3:0] exp);
    cp(1'h1, 2'h2, CFG, v, HTV_EXC_NONE, '0);
    @(posedge clk);
    #1;
    chk({guest_serror, guest_irq, guest_fiq, stage2_eff}, exp, "levels");
  endtask
  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #(3000 * 100);
    n_errors++;
    stop_test;
  end
  // ==========================================================
  // test sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 1'h0;
    cp(1'h0, 2'h2, CFG, '0, HTV_EXC_NONE, '0);
    cp(1'h1, 2'h2, CFG, 32'hFFFF_FFFF, HTV_EXC_NONE, '0);
    cp(1'h1, 2'h1, CFG, '0, HTV_EXC_NONE, '0);
    cp(1'h0, 2'h2, CFG, '0, HTV_EXC_NONE, HTV_WMASK);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h0, 4'h3, 3'h2}, '0, HTV_EXC_HYP, '0);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h0, 4'h2, 3'h7}, '0, HTV_EXC_HYP, '0);
    cp(1'h0, 2'h0, {4'hF, 3'h0, 4'h0, 4'h0, 3'h1}, '0, HTV_EXC_HYP, '0);
    cp(1'h1, 2'h0, {4'hF, 3'h2, 4'h0, 4'h0, 3'h0}, 32'h1, HTV_EXC_HYP, '0);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h0, 4'h0, 3'h6}, '0, HTV_EXC_HYP, '0);
    cp(1'h0, 2'h1, ALT, '0, HTV_EXC_HYP, '0);
    cp(1'h0, 2'h0, ALT, '0, HTV_EXC_HYP, '0);
    alt_isa_undef_el0 = 1'h1;
    cp(1'h0, 2'h0, ALT, '0, HTV_EXC_UNDEF, '0);
    cp(1'h1, 2'h1, {4'hA, 3'h7, 4'h0, 4'h0, 3'h0}, 32'h5, HTV_EXC_NONE, '0);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h9, 4'h0, 3'h0}, '0, HTV_EXC_HYP, '0);
    lv(32'h0800_01F8, 4'h0);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h0, 4'h3, 3'h2}, '0, HTV_EXC_NONE, '0);
    cp(1'h0, 2'h1, {4'hF, 3'h0, 4'h9, 4'h0, 3'h0}, '0, HTV_EXC_NONE, '0);
    lv(32'h0000_01F8, 4'hE);
    lv(32'h0000_01C0, 4'h0);
    lv(32'h0000_0038, 4'h0);
    lv(32'h0000_0120, 4'h8);
    lv(32'h0000_0090, 4'h4);
    lv(32'h0000_0048, 4'h2);
    lv(32'h0000_0001, 4'h1);
    lv(32'h0000_1000, 4'h1);
    chk({def_map_attr, def_map_shared, def_map_exec}, {HTV_DEF_ATTR, 1'h0, 1'h1}, "default map");
    for (int u = 0; u < 4; u++) begin
      cp(1'h1, 2'h2, CFG, {20'h0, u[1:0], 10'h200}, HTV_EXC_NONE, '0);
      for (int d = 0; d < 4; d++) begin
        bi(2'h1, d[1:0], (u > d) ? u[1:0] : d[1:0], 1'h1);
        bi(2'h0, d[1:0], (u > d) ? u[1:0] : d[1:0], 1'h0);
        bi(2'h2, d[1:0], d[1:0], 1'h0);
      end
    end
    cp(1'h1, 2'h2, CFG, 32'h0000_6000, HTV_EXC_NONE, '0);
    bi(2'h1, 2'h2, 2'h2, 1'h0);
    wt(1'h0, 2'h1, 1'h1, 1'h1, 1'h1, HTV_EXC_HYP, 1'h0);
    wt(1'h1, 2'h0, 1'h1, 1'h1, 1'h1, HTV_EXC_HYP, 1'h0);
    wt(1'h0, 2'h0, 1'h0, 1'h1, 1'h1, HTV_EXC_UNDEF, 1'h0);
    wt(1'h1, 2'h0, 1'h0, 1'h1, 1'h1, HTV_EXC_UNDEF, 1'h0);
    wt(1'h0, 2'h1, 1'h1, 1'h0, 1'h1, HTV_EXC_NONE, 1'h0);
    wt(1'h1, 2'h1, 1'h1, 1'h1, 1'h0, HTV_EXC_NONE, 1'h0);
    wt(1'h1, 2'h2, 1'h1, 1'h1, 1'h1, HTV_EXC_NONE, 1'h1);
    cp(1'h1, 2'h2, CFG, '0, HTV_EXC_NONE, '0);
    wt(1'h0, 2'h1, 1'h1, 1'h1, 1'h1, HTV_EXC_NONE, 1'h1);
    stop_test;
  end
endmodule
